// ---- logic/cfl_loader.sv ----
// Configuration frame loader: memory clear, bitstream loading, readback CRC
`timescale 1ns/1ps
`default_nettype none
module cfl_loader
	import cfl_pkg::*;
#(
	parameter int FAMILY = 0,
	parameter int ROWS = 10,
	parameter int COLS = 10,
	parameter int FRAME_CNT_W = 12,
	parameter int BIT_CNT_W = 10,
	parameter int DATA_W = 8,
	parameter int LOW_VOLT = 0,
	parameter int DELAY_CYC = PWRUP_DELAY_CYC
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_cclk,
	input wire logic i_din,
	input wire logic i_program_n,
	input wire logic i_init_n,
	output logic o_init_n,
	output logic o_init_oe,
	input wire logic i_mode_select_0,
	input wire logic i_crc_check_en,
	output logic o_wr_valid,
	output logic [DATA_W-1:0] o_wr_data,
	input wire logic i_wr_ready,
	output logic [1:0] o_phase,
	output logic o_done,
	output logic o_cfg_error,
	input wire logic i_rb_start,
	input wire logic i_rb_valid,
	input wire logic i_rb_bit,
	input wire logic i_rb_last,
	output logic o_rb_valid,
	output logic o_rb_bit
);
	localparam int BPF = cfl_bits_per_frame(FAMILY, ROWS);
	localparam int NFR = cfl_frames(FAMILY, COLS);
	localparam int POSTB = (FAMILY == 0) ? F1_POST : F2_POST;
	localparam int DATA_BITS = BPF - START_BITS - CHECK_BITS;
	localparam int SLAVE_CYC = (LOW_VOLT != 0) ? DELAY_CYC / 100 * (100 + LOW_VOLT_EXTRA_PCT)
		: DELAY_CYC;
	localparam int MASTER_CYC = SLAVE_CYC * MASTER_DELAY_MULT;
	localparam int TIMER_W = $clog2(MASTER_CYC + 1);
	localparam logic [BIT_CNT_W-1:0] DATA_LAST = BIT_CNT_W'(DATA_BITS - 1);
	localparam logic [BIT_CNT_W-1:0] CHK_LAST = BIT_CNT_W'(CHECK_BITS - 1);
	localparam logic [BIT_CNT_W-1:0] LEN_LAST = BIT_CNT_W'(LEN_W - 1);
	localparam logic [BIT_CNT_W-1:0] POST_LAST = BIT_CNT_W'(POSTB - 1);
	localparam logic [BIT_CNT_W-1:0] SU_LAST = BIT_CNT_W'(STARTUP_CLKS - 1);
	localparam logic [FRAME_CNT_W-1:0] FR_LAST = FRAME_CNT_W'(NFR - 1);
	localparam logic [TIMER_W-1:0] T_SLAVE = TIMER_W'(SLAVE_CYC);
	localparam logic [TIMER_W-1:0] T_MASTER = TIMER_W'(MASTER_CYC);
	localparam logic [3:0] RB_LAST = 4'(RB_TAIL_BITS - 1);

	//////////////////////////////////////////////////////////////////////////
	// Elaboration checks on sizing
	if (FRAME_CNT_W < $clog2(NFR + 1) || BIT_CNT_W < $clog2(DATA_BITS + 1)
		|| BIT_CNT_W < $clog2(LEN_W + 1)) // [R27]
	begin : g_bad_width
		$error("counter widths too narrow for device size");
	end
	if (cfl_image_bits(FAMILY, ROWS, COLS) >= (1 << LEN_W)) // [R4] [R8]
	begin : g_bad_len
		$error("image does not fit the length count");
	end
	if (FAMILY < 0 || FAMILY > 1 || DATA_W < 2 || ROWS < 0 || COLS < 0 || DELAY_CYC < 1)
	begin : g_bad_param
		$error("unsupported loader parameters");
	end

	//////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers
	logic rst_meta_reg, rstn;
	logic [4:0] sync1_reg, sync2_reg;
	logic cclk_prev_reg;
	logic cclk_s, din_s, prog_n_s, init_in_s, m0_s, cclk_rise;

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			rst_meta_reg <= 1'b0;
			rstn <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rstn <= rst_meta_reg;
		end
	end

	// No reset, so the mode pin is settled when the cell test picks the delay
	always_ff @(posedge i_clk)
	begin
		sync1_reg <= {i_mode_select_0, i_init_n, i_program_n, i_din, i_cclk};
		sync2_reg <= sync1_reg;
		cclk_prev_reg <= sync2_reg[0];
	end

	assign cclk_s = sync2_reg[0];
	assign din_s = sync2_reg[1];
	assign prog_n_s = sync2_reg[2];
	assign init_in_s = sync2_reg[3];
	assign m0_s = sync2_reg[4];
	// Link edges are found on the clean copy; bench link period allows this
	assign cclk_rise = cclk_s && !cclk_prev_reg;

	//////////////////////////////////////////////////////////////////////////
	// Configuration sequencer
	cfl_state_t state_reg, state_next;
	logic [FRAME_CNT_W-1:0] pass_reg, pass_next, frame_reg, frame_next;
	logic [TIMER_W-1:0] timer_reg, timer_next;
	logic [1:0] cell_reg, cell_next, phase_reg, phase_next;
	logic [3:0] shift_reg, shift_next, chk_word;
	logic [LEN_W-1:0] len_reg, len_next, ccnt_reg, ccnt_next;
	logic [BIT_CNT_W-1:0] cnt_reg, cnt_next;
	logic [DATA_W-1:0] word_reg, word_next;
	logic [$clog2(DATA_W)-1:0] wbits_reg, wbits_next;
	logic init_oe_reg, init_oe_next, done_reg, done_next, err_reg, err_next;
	logic crc_clr, crc_en, push, buf_ready;
	logic [15:0] crc_cfg;
	logic [3:0] expect_chk;

	assign chk_word = {shift_reg[2:0], din_s};
	assign expect_chk = i_crc_check_en ? crc_cfg[15:12] : CHECK_CONST; // [R22] [R23]

	always_comb
	begin
		state_next = state_reg;
		pass_next = pass_reg;
		frame_next = frame_reg;
		timer_next = (timer_reg != '0) ? timer_reg - 1'b1 : timer_reg;
		cell_next = cell_reg;
		shift_next = shift_reg;
		len_next = len_reg;
		ccnt_next = ccnt_reg;
		cnt_next = cnt_reg;
		word_next = word_reg;
		wbits_next = wbits_reg;
		init_oe_next = init_oe_reg;
		done_next = done_reg;
		err_next = err_reg;
		crc_clr = 1'b0;
		crc_en = 1'b0;
		push = 1'b0;
		if (state_reg >= ST_HUNT && state_reg <= ST_STARTUP && cclk_rise)
			ccnt_next = ccnt_reg + 1'b1; // [R9]
		unique case (state_reg)
			ST_CELL_WR:
			begin
				cell_next = CELL_PATTERN;
				state_next = ST_CELL_RD;
			end
			ST_CELL_RD:
			begin
				if (cell_reg == CELL_PATTERN) // [R17]
				begin
					timer_next = m0_s ? T_SLAVE : T_MASTER; // [R18] [R19]
					pass_next = '0;
					state_next = ST_CLEAR;
				end
				else
					state_next = ST_CELL_WR;
			end
			ST_CLEAR, ST_CLEAR_LAST:
			begin
				init_oe_next = 1'b1;
				pass_next = pass_reg + 1'b1;
				if (pass_reg == FR_LAST)
				begin
					pass_next = '0;
					if (state_reg == ST_CLEAR_LAST)
					begin
						init_oe_next = 1'b0; // [R25]
						state_next = ST_INIT_WAIT;
					end
					else if (prog_n_s && timer_reg == '0) // [R18] [R24]
						state_next = ST_CLEAR_LAST;
				end
			end
			ST_INIT_WAIT:
			begin
				if (init_in_s) // [R20]
				begin
					crc_clr = 1'b1; // [R26]
					ccnt_next = '0;
					shift_next = HUNT_INIT;
					frame_next = '0;
					state_next = ST_HUNT;
				end
			end
			ST_HUNT:
			begin
				if (cclk_rise)
				begin
					shift_next = chk_word;
					if (chk_word == PREAMBLE) // [R9]
					begin
						cnt_next = '0;
						state_next = ST_LEN;
					end
				end
			end
			ST_LEN:
			begin
				if (cclk_rise)
				begin
					len_next = {len_reg[LEN_W-2:0], din_s};
					cnt_next = cnt_reg + 1'b1;
					if (cnt_reg == LEN_LAST)
						state_next = ST_SEP;
				end
			end
			ST_SEP, ST_GAP:
			begin
				if (cclk_rise)
				begin
					if (!din_s)
					begin
						crc_en = 1'b1;
						cnt_next = '0;
						wbits_next = '0;
						state_next = ST_DATA;
					end
					else if (state_reg == ST_GAP && i_crc_check_en)
						state_next = ST_ERROR; // [R10]
				end
			end
			ST_DATA:
			begin
				if (cclk_rise)
				begin
					crc_en = 1'b1;
					word_next = {word_reg[DATA_W-2:0], din_s};
					wbits_next = wbits_reg + 1'b1;
					cnt_next = cnt_reg + 1'b1;
					if (wbits_reg == ($clog2(DATA_W))'(DATA_W - 1) || cnt_reg == DATA_LAST)
					begin
						push = 1'b1;
						wbits_next = '0;
					end
					if (cnt_reg == DATA_LAST) // [R1] [R5] [R11]
					begin
						cnt_next = '0;
						state_next = ST_CHK;
					end
					// Link cannot be stalled, so a full buffer halts loading
					if (push && !buf_ready)
						state_next = ST_ERROR;
				end
			end
			ST_CHK:
			begin
				if (cclk_rise)
				begin
					shift_next = chk_word;
					cnt_next = cnt_reg + 1'b1;
					if (cnt_reg == CHK_LAST)
					begin
						cnt_next = '0;
						frame_next = frame_reg + 1'b1;
						if (chk_word != expect_chk) // [R11] [R12] [R22] [R23]
							state_next = ST_ERROR;
						else if (frame_reg == FR_LAST) // [R2] [R6]
							state_next = ST_POST;
						else
							state_next = ST_GAP;
					end
				end
			end
			ST_POST:
			begin
				if (cclk_rise)
				begin
					cnt_next = cnt_reg + 1'b1;
					if (cnt_reg == POST_LAST) // [R3] [R7]
						state_next = ST_WAIT_LEN;
				end
			end
			ST_WAIT_LEN:
			begin
				if (ccnt_reg >= len_reg) // [R9]
				begin
					cnt_next = '0;
					state_next = ST_STARTUP;
				end
			end
			ST_STARTUP:
			begin
				if (cclk_rise)
				begin
					cnt_next = cnt_reg + 1'b1;
					if (cnt_reg == SU_LAST)
					begin
						done_next = 1'b1;
						state_next = ST_DONE;
					end
				end
			end
			ST_DONE:
				state_next = ST_DONE;
			ST_ERROR:
				state_next = ST_ERROR;
		endcase
		if (state_next == ST_ERROR)
		begin
			init_oe_next = 1'b1; // [R12]
			err_next = 1'b1;
		end
		// Reprogramming clears again but never reloads the delay timer
		if (!prog_n_s && state_reg != ST_CELL_WR && state_reg != ST_CELL_RD) // [R21] [R24]
		begin
			state_next = ST_CLEAR;
			pass_next = (state_reg == ST_CLEAR) ? pass_next : '0;
			init_oe_next = 1'b1;
			done_next = 1'b0;
			err_next = 1'b0;
		end
		if (state_next <= ST_CLEAR_LAST)
			phase_next = PH_CLEAR; // [R16]
		else if (state_next == ST_INIT_WAIT)
			phase_next = PH_INIT;
		else if (state_next >= ST_STARTUP && state_next != ST_ERROR)
			phase_next = PH_START;
		else
			phase_next = PH_LOAD;
	end

	always_ff @(posedge i_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg <= ST_CELL_WR;
			pass_reg <= '0;
			frame_reg <= '0;
			timer_reg <= '0;
			cell_reg <= 2'h0;
			shift_reg <= HUNT_INIT;
			len_reg <= '0;
			ccnt_reg <= '0;
			cnt_reg <= '0;
			word_reg <= '0;
			wbits_reg <= '0;
			init_oe_reg <= 1'b1;
			done_reg <= 1'b0;
			err_reg <= 1'b0;
			phase_reg <= PH_CLEAR;
		end
		else
		begin
			state_reg <= state_next;
			pass_reg <= pass_next;
			frame_reg <= frame_next;
			timer_reg <= timer_next;
			cell_reg <= cell_next;
			shift_reg <= shift_next;
			len_reg <= len_next;
			ccnt_reg <= ccnt_next;
			cnt_reg <= cnt_next;
			word_reg <= word_next;
			wbits_reg <= wbits_next;
			init_oe_reg <= init_oe_next;
			done_reg <= done_next;
			err_reg <= err_next;
			phase_reg <= phase_next;
		end
	end

	cfl_crc16 u_crc_cfg (
		.i_clk(i_clk),
		.i_rstn(rstn),
		.i_clear(crc_clr),
		.i_en(crc_en),
		.i_bit(din_s),
		.o_crc(crc_cfg)
	);

	cfl_buf2 #(.W(DATA_W)) u_buf (
		.i_clk(i_clk),
		.i_rstn(rstn),
		.i_valid(push),
		.i_data(word_next),
		.o_ready(buf_ready),
		.o_valid(o_wr_valid),
		.o_data(o_wr_data),
		.i_ready(i_wr_ready)
	);

	//////////////////////////////////////////////////////////////////////////
	// Readback stream with checksum tail
	logic rb_busy_reg, rb_busy_next, rb_tail_reg, rb_tail_next;
	logic rb_valid_reg, rb_valid_next, rb_bit_reg, rb_bit_next;
	logic [3:0] rb_cnt_reg, rb_cnt_next;
	logic rb_clr, rb_en;
	logic [15:0] crc_rb;

	assign rb_clr = i_rb_start && done_reg; // [R26]
	assign rb_en = rb_busy_reg && !rb_tail_reg && i_rb_valid && !rb_clr;

	always_comb
	begin
		rb_busy_next = rb_busy_reg;
		rb_tail_next = rb_tail_reg;
		rb_cnt_next = rb_cnt_reg;
		rb_bit_next = rb_bit_reg;
		rb_valid_next = 1'b0;
		if (rb_clr)
		begin
			rb_busy_next = 1'b1;
			rb_tail_next = 1'b0;
		end
		else if (rb_en)
		begin
			rb_bit_next = i_rb_bit;
			rb_valid_next = 1'b1;
			rb_cnt_next = 4'h0;
			rb_tail_next = i_rb_last;
		end
		else if (rb_tail_reg)
		begin
			rb_bit_next = crc_rb[4'hf - rb_cnt_reg]; // [R13]
			rb_valid_next = 1'b1;
			rb_cnt_next = rb_cnt_reg + 4'h1;
			if (rb_cnt_reg == RB_LAST)
			begin
				rb_busy_next = 1'b0;
				rb_tail_next = 1'b0;
			end
		end
		if (!done_reg)
		begin
			rb_busy_next = 1'b0;
			rb_tail_next = 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rb_busy_reg <= 1'b0;
			rb_tail_reg <= 1'b0;
			rb_cnt_reg <= 4'h0;
			rb_bit_reg <= 1'b0;
			rb_valid_reg <= 1'b0;
		end
		else
		begin
			rb_busy_reg <= rb_busy_next;
			rb_tail_reg <= rb_tail_next;
			rb_cnt_reg <= rb_cnt_next;
			rb_bit_reg <= rb_bit_next;
			rb_valid_reg <= rb_valid_next;
		end
	end

	cfl_crc16 u_crc_rb (
		.i_clk(i_clk),
		.i_rstn(rstn),
		.i_clear(rb_clr),
		.i_en(rb_en),
		.i_bit(i_rb_bit),
		.o_crc(crc_rb)
	);

	assign o_init_oe = init_oe_reg;
	assign o_init_n = 1'b0 & init_oe_reg;
	assign o_phase = phase_reg;
	assign o_done = done_reg;
	assign o_cfg_error = err_reg;
	assign o_rb_valid = rb_valid_reg;
	assign o_rb_bit = rb_bit_reg;

	//////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!rstn);

	sequence s_chk_end;
		state_reg == ST_CHK && cclk_rise && cnt_reg == CHK_LAST && prog_n_s;
	endsequence
	sequence s_rb_last;
		rb_en && i_rb_last && done_reg;
	endsequence

	AST_CLEAR_ORDER: assert property ((state_reg == ST_CLEAR_LAST && prog_n_s)
		|=> state_reg inside {ST_CLEAR_LAST, ST_INIT_WAIT}) // [R16]
		else $error("final clear pass left out of order");
	AST_TIMER_HOLDS: assert property ((state_reg == ST_CLEAR && timer_reg > 1)
		|=> state_reg == ST_CLEAR) // [R18]
		else $error("clear ended while delay ran");
	AST_SLAVE_DELAY: assert property ((state_reg == ST_CELL_RD && cell_reg == CELL_PATTERN && m0_s)
		|=> timer_reg == T_SLAVE ##1 timer_reg == T_SLAVE - 1'b1) // [R17] [R18]
		else $error("slave delay not loaded");
	AST_MASTER_DELAY: assert property ((state_reg == ST_CELL_RD && cell_reg == CELL_PATTERN && !m0_s)
		|=> timer_reg == T_MASTER) // [R19]
		else $error("master delay not four times slave");
	AST_NO_RELOAD: assert property ($past(state_reg) != ST_CELL_RD |-> timer_reg <= $past(timer_reg))
		else $error("delay timer reloaded outside power-up"); // [R21]
	AST_PROG_CLEAR: assert property ((!prog_n_s && state_reg > ST_CELL_RD)
		|=> state_reg == ST_CLEAR && init_oe_reg) // [R24]
		else $error("program low did not hold clear");
	AST_INIT_RELEASE: assert property ($fell(init_oe_reg) |-> $past(state_reg) == ST_CLEAR_LAST
		&& $past(pass_reg) == FR_LAST) // [R25]
		else $error("status released before final pass");
	AST_FRAME_ERR: assert property (s_chk_end ##0 (chk_word != expect_chk)
		|=> (state_reg == ST_ERROR && init_oe_reg && err_reg) [*2]) // [R12] [R22] [R23]
		else $error("frame error did not halt loading");
	AST_FILL_CRC: assert property ((state_reg == ST_GAP && cclk_rise && din_s && i_crc_check_en
		&& prog_n_s) |=> state_reg == ST_ERROR) // [R10]
		else $error("fill bit accepted with CRC checking");
	AST_FRAME_LEN: assert property ((state_reg == ST_DATA && cclk_rise && cnt_reg == DATA_LAST
		&& prog_n_s && buf_ready) |=> state_reg == ST_CHK) // [R1] [R5] [R11]
		else $error("frame length wrong");
	AST_RB_TAIL: assert property (s_rb_last |=> rb_valid_reg [*8] ##1 rb_valid_reg [*4]
		##1 !rb_valid_reg) // [R13]
		else $error("readback tail not eleven bits");
	AST_RB_CRC: assert property (s_rb_last |=> ##1 rb_bit_reg == $past(crc_rb[15])) // [R14]
		else $error("readback tail does not start with crc msb");
	AST_CRC_CLEAR: assert property (rb_clr |=> crc_rb == CRC_INIT) // [R26]
		else $error("readback crc not cleared");
	AST_DONE_SEQ: assert property ($rose(done_reg) |-> $past(state_reg) == ST_STARTUP) // [R16]
		else $error("done raised outside start-up");
endmodule : cfl_loader
`default_nettype wire

// ---- logic/cfl_pkg.sv ----
// Constants, types and helper functions of the configuration frame loader
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R1 - Family one frame length from rows
// R2 - Family one frame count from columns
// R3 - Family one data adds eight postamble bits
// R4 - Family one image adds header bits
// R5 - Family two frame length from rows
// R6 - Family two frame count from columns
// R7 - Family two data adds five postamble bits
// R8 - Family two image rounded to bytes
// R9 - Leading ones tolerated, length counts them
// R10 - Trailing frame ones only without CRC
// R11 - Last four frame bits are check
// R12 - Frame error aborts, drives status low
// R13 - Readback appends eleven checksum msbs
// R14 - Readback checksum is serial CCITT CRC
// R15 - Operator keeps readback data state-free
// R16 - Clear, init, load, start-up in order
// R17 - Sample cell test before delay timer
// R18 - Slave power-up delay sixteen milliseconds
// R19 - Master delay four times slave delay
// R20 - Wait until shared status line released
// R21 - Delay only at power-up, not reprogram
// R22 - Without CRC compare constant end field
// R23 - With CRC compare partial running check
// R24 - Program low keeps repeating clear passes
// R25 - Release status after final clear pass
// R26 - CRC polynomial fixed, cleared per pass
// R27 - Counter widths are size parameters
//////////////////////////////////////////////////////////////////////////////
package cfl_pkg;
	localparam int CLK_FREQ_MHZ = 200;
	localparam int PWRUP_DELAY_MS = 16;
	localparam int PWRUP_DELAY_CYC = PWRUP_DELAY_MS * 1000 * CLK_FREQ_MHZ;
	localparam int MASTER_DELAY_MULT = 4;
	localparam int LOW_VOLT_EXTRA_PCT = 10;
	localparam int START_BITS = 1;
	localparam int CHECK_BITS = 4;
	localparam int F1_ROW_BITS = 10, F1_TOP = 7, F1_BOT = 13, F1_EXTRA = 1;
	localparam int F1_COL_FR = 36, F1_LEFT = 26, F1_RIGHT = 41, F1_XFR = 1, F1_POST = 8;
	localparam int F2_ROW_BITS = 13, F2_TOP = 9, F2_BOT = 17, F2_EXTRA = 8;
	localparam int F2_COL_FR = 47, F2_LEFT = 27, F2_RIGHT = 52, F2_XFR = 4, F2_POST = 5;
	localparam int HEADER_BITS = 40;
	localparam int IMAGE_TAIL_BITS = 8;
	localparam int LEN_W = 24;
	localparam int STARTUP_CLKS = 4;
	localparam int RB_TAIL_BITS = 11;
	localparam logic [3:0] PREAMBLE = 4'h2;
	localparam logic [3:0] CHECK_CONST = 4'h6;
	localparam logic [3:0] HUNT_INIT = 4'hf;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'h0000;
	localparam logic [1:0] CELL_PATTERN = 2'h2;
	localparam logic [1:0] PH_CLEAR = 2'h0, PH_INIT = 2'h1, PH_LOAD = 2'h2, PH_START = 2'h3;

	typedef enum logic [3:0] {
		ST_CELL_WR = 4'h0, ST_CELL_RD = 4'h1, ST_CLEAR = 4'h2, ST_CLEAR_LAST = 4'h3,
		ST_INIT_WAIT = 4'h4, ST_HUNT = 4'h5, ST_LEN = 4'h6, ST_SEP = 4'h7,
		ST_DATA = 4'h8, ST_CHK = 4'h9, ST_GAP = 4'ha, ST_POST = 4'hb,
		ST_WAIT_LEN = 4'hc, ST_STARTUP = 4'hd, ST_DONE = 4'he, ST_ERROR = 4'hf
	} cfl_state_t;

	function automatic int cfl_bits_per_frame(input int family, input int rows);
		if (family == 0)
			return F1_ROW_BITS * rows + F1_TOP + F1_BOT + F1_EXTRA + START_BITS + CHECK_BITS;
		return F2_ROW_BITS * rows + F2_TOP + F2_BOT + F2_EXTRA + START_BITS + CHECK_BITS;
	endfunction : cfl_bits_per_frame

	function automatic int cfl_frames(input int family, input int cols);
		if (family == 0)
			return F1_COL_FR * cols + F1_LEFT + F1_RIGHT + F1_XFR;
		return F2_COL_FR * cols + F2_LEFT + F2_RIGHT + F2_XFR;
	endfunction : cfl_frames

	function automatic int cfl_image_bits(input int family, input int rows, input int cols);
		int prog;
		prog = cfl_bits_per_frame(family, rows) * cfl_frames(family, cols)
			+ ((family == 0) ? F1_POST : F2_POST);
		if (family == 0)
			return prog + HEADER_BITS + IMAGE_TAIL_BITS;
		return ((prog + HEADER_BITS + IMAGE_TAIL_BITS + 7) / 8) * 8;
	endfunction : cfl_image_bits
endpackage : cfl_pkg

// ---- logic/cfl_crc16.sv ----
// Serial sixteen-bit CRC shift register
`timescale 1ns/1ps
`default_nettype none
module cfl_crc16
	import cfl_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_clear,
	input wire logic i_en,
	input wire logic i_bit,
	output logic [15:0] o_crc
);
	logic [15:0] crc_reg;
	logic [15:0] crc_next;
	logic fb;

	always_comb
	begin
		fb = crc_reg[15] ^ i_bit;
		crc_next = crc_reg;
		if (i_clear)
			crc_next = CRC_INIT; // [R26]
		else if (i_en)
			crc_next = {crc_reg[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000); // [R14] [R26]
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			crc_reg <= 16'h0000;
		else
			crc_reg <= crc_next;
	end

	assign o_crc = crc_reg;
endmodule : cfl_crc16
`default_nettype wire

// ---- logic/cfl_buf2.sv ----
// Two-entry buffer with registered head
`timescale 1ns/1ps
`default_nettype none
module cfl_buf2 #(
	parameter int W = 8
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_valid,
	input wire logic [W-1:0] i_data,
	output logic o_ready,
	output logic o_valid,
	output logic [W-1:0] o_data,
	input wire logic i_ready
);
	logic head_v_reg, head_v_next, tail_v_reg, tail_v_next;
	logic [W-1:0] head_reg, head_next, tail_reg, tail_next;
	logic push, pop;

	// Full means the tail is taken; head stays a flop so outputs are clean
	assign o_ready = !tail_v_reg;
	assign push = i_valid && !tail_v_reg;
	assign pop = head_v_reg && i_ready;

	always_comb
	begin
		head_v_next = head_v_reg;
		tail_v_next = tail_v_reg;
		head_next = head_reg;
		tail_next = tail_reg;
		if (pop)
		begin
			if (tail_v_reg)
			begin
				head_next = tail_reg;
				tail_v_next = 1'b0;
			end
			else if (push)
				head_next = i_data;
			else
				head_v_next = 1'b0;
		end
		else if (push)
		begin
			if (!head_v_reg)
			begin
				head_next = i_data;
				head_v_next = 1'b1;
			end
			else
			begin
				tail_next = i_data;
				tail_v_next = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			head_v_reg <= 1'b0;
			tail_v_reg <= 1'b0;
			head_reg <= '0;
			tail_reg <= '0;
		end
		else
		begin
			head_v_reg <= head_v_next;
			tail_v_reg <= tail_v_next;
			head_reg <= head_next;
			tail_reg <= tail_next;
		end
	end

	assign o_valid = head_v_reg;
	assign o_data = head_reg;
endmodule : cfl_buf2
`default_nettype wire

// ---- tb/cfl_src_model.sv ----
// Serial configuration source model
`timescale 1ns/1ps
`default_nettype none
module cfl_src_model (
	output logic o_cclk,
	output logic o_din
);
	initial
	begin
		o_cclk = 1'b0;
		o_din = 1'b1;
	end
	// One bit per 80 ns clock, clock idles low between bits
	task automatic send_bit(input logic b);
		o_din = b;
		#40 o_cclk = 1'b1;
		#40 o_cclk = 1'b0;
		o_din = ~b; // Stale data never looks valid
	endtask : send_bit
endmodule : cfl_src_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench of the frame loader
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import cfl_pkg::*;
	// No rows or columns keeps the image short
	localparam int BPF = F1_TOP + F1_BOT + F1_EXTRA + START_BITS + CHECK_BITS;
	localparam int NFR = F1_LEFT + F1_RIGHT + F1_XFR;
	localparam int LEN = 8 + 4 + 24 + 4 + BPF * NFR + F1_POST;
	localparam int DLY = 20;
	logic mode_sel = 1'b1, crc_en = 1'b0;
	logic i_clk = 1'b0, i_rstn = 1'b0, i_program_n = 1'b1, wr_ready = 1'b1;
	logic rb_start = 1'b0, rb_valid = 1'b0, rb_bit = 1'b0, rb_last = 1'b0;
	logic o_init_n, o_init_oe, o_wr_valid, o_done, o_cfg_error, o_rb_valid, o_rb_bit;
	logic [7:0] o_wr_data, first_w;
	logic [1:0] o_phase;
	logic [7:0] cyc = 8'h00;
	wire cclk, din, init_n;
	int err_count = 0, n_compared = 0, n_words = 0, n_wait = 0;
	assign init_n = !o_init_oe; // Pull-up when released
	cfl_src_model u_src (.o_cclk(cclk), .o_din(din));
	cfl_loader #(.ROWS(0), .COLS(0), .DELAY_CYC(DLY)) u_dut (.i_clk(i_clk),
		.i_rstn(i_rstn), .i_cclk(cclk), .i_din(din), .i_program_n(i_program_n),
		.i_init_n(init_n), .o_init_n(o_init_n), .o_init_oe(o_init_oe),
		.i_mode_select_0(mode_sel), .i_crc_check_en(crc_en), .o_wr_valid(o_wr_valid),
		.o_wr_data(o_wr_data), .i_wr_ready(wr_ready), .o_phase(o_phase),
		.o_done(o_done), .o_cfg_error(o_cfg_error), .i_rb_start(rb_start),
		.i_rb_valid(rb_valid), .i_rb_bit(rb_bit), .i_rb_last(rb_last),
		.o_rb_valid(o_rb_valid), .o_rb_bit(o_rb_bit));
	initial
	begin
		forever #2.5 i_clk = ~i_clk;
	end
	// Receiver stalls half the time to exercise the buffer
	always @(posedge i_clk)
	begin
		cyc <= cyc + 8'h01;
		wr_ready <= !cyc[6];
		if (o_wr_valid === 1'b1 && wr_ready === 1'b1)
		begin
			if (n_words == 0)
				first_w = o_wr_data;
			n_words++;
		end
	end
	//////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
			err_count++;
		end
	endtask : chk
	task automatic wait_init;
		int i;
		for (i = 0; i < 5000 && o_init_oe !== 1'b0; i++)
			@(posedge i_clk) #1;
		n_wait = i;
		repeat (10) @(posedge i_clk);
	endtask : wait_init
	task automatic load(input logic [3:0] cf, input int nf, input logic crc);
		int i;
		int j;
		logic b;
		logic [15:0] c;
		c = CRC_INIT;
		for (i = 0; i < 8; i++) u_src.send_bit(1'b1);
		for (i = 3; i >= 0; i--) u_src.send_bit(PREAMBLE[i]);
		for (i = 23; i >= 0; i--) u_src.send_bit(LEN[i]);
		for (i = 0; i < 4; i++) u_src.send_bit(1'b1);
		for (j = 0; j < nf; j++)
		begin
			// Start bit then data; the running check never covers the check field
			for (i = -1; i < BPF - 5; i++)
			begin
				b = (i >= 0) && i[0];
				c = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
				u_src.send_bit(b);
			end
			if (crc)
				cf = c[15:12];
			for (i = 3; i >= 0; i--) u_src.send_bit(cf[i]);
		end
		for (i = 0; i < F1_POST + 8; i++) u_src.send_bit(1'b1);
	endtask : load
	//////////////////////////////////////////////////////////////////////////////
	task automatic t_powerup;
		repeat (20) @(posedge i_clk);
		chk("init_oe in reset", 1, o_init_oe);
		chk("phase in reset", PH_CLEAR, o_phase);
		i_rstn <= 1'b1;
		wait_init();
		chk("init released", 0, o_init_oe);
		chk("slave delay", 1, n_wait < MASTER_DELAY_MULT * DLY + NFR);
		chk("image bytes", 0, cfl_image_bits(1, 0, 0) % 8);
	endtask : t_powerup
	task automatic t_load_good;
		int i;
		load(CHECK_CONST, NFR, 1'b0);
		for (i = 0; i < 2000 && o_done !== 1'b1; i++)
			@(posedge i_clk);
		chk("done", 1, o_done);
		chk("phase", PH_START, o_phase);
		chk("error", 0, o_cfg_error);
		chk("words", NFR * 3, n_words);
		chk("first word", 8'h55, first_w);
	endtask : t_load_good
	task automatic t_readback;
		logic [15:0] c;
		int i;
		c = 16'h1021; // Single one bit into a cleared register
		@(posedge i_clk) rb_start <= 1'b1;
		@(posedge i_clk)
		begin
			rb_start <= 1'b0;
			rb_valid <= 1'b1;
			rb_bit <= 1'b1;
			rb_last <= 1'b1;
		end
		@(posedge i_clk)
		begin
			rb_valid <= 1'b0;
			rb_last <= 1'b0;
		end
		#1;
		for (i = 0; i < 4 && o_rb_valid !== 1'b1; i++)
			@(posedge i_clk) #1;
		chk("rb bit", 2'h3, {o_rb_valid, o_rb_bit});
		for (i = 15; i >= 5; i--)
		begin
			@(posedge i_clk) #1;
			chk("rb crc", {1'b1, c[i]}, {o_rb_valid, o_rb_bit});
		end
		@(posedge i_clk) #1;
		chk("rb end", 0, o_rb_valid);
	endtask : t_readback
	task automatic t_load_bad;
		int i;
		@(posedge i_clk) i_program_n <= 1'b0;
		repeat (40) @(posedge i_clk);
		chk("prog low init", 1, o_init_oe);
		chk("prog low done", 0, o_done);
		i_program_n <= 1'b1;
		wait_init();
		load(4'h7, 1, 1'b0);
		for (i = 0; i < 200 && o_cfg_error !== 1'b1; i++)
			@(posedge i_clk);
		chk("frame error", 1, o_cfg_error);
		chk("init pulled", 1, o_init_oe);
		chk("no done", 0, o_done);
		chk("init drive", 0, o_init_n);
	endtask : t_load_bad
	task automatic t_master_crc;
		int i;
		@(posedge i_clk)
		begin
			i_rstn <= 1'b0;
			mode_sel <= 1'b0;
			crc_en <= 1'b1;
		end
		repeat (20) @(posedge i_clk);
		i_rstn <= 1'b1;
		wait_init();
		chk("master delay", 1, n_wait >= MASTER_DELAY_MULT * DLY + NFR);
		load(4'h0, NFR, 1'b1);
		for (i = 0; i < 2000 && o_done !== 1'b1; i++)
			@(posedge i_clk) #1;
		chk("crc done", 1, o_done);
		chk("crc error", 0, o_cfg_error);
		chk("crc words", NFR * 6 + 3, n_words);
	endtask : t_master_crc
	//////////////////////////////////////////////////////////////////////////////
	task automatic close_out;
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	initial
	begin
		t_powerup();
		t_load_good();
		t_readback();
		t_load_bad();
		t_master_crc();
		close_out();
	end
	initial
	begin
		#450000;
		err_count++;
		close_out();
	end
endmodule : tb_top
`default_nettype wire
